// file: rtl/dec_skip_pkg.sv
// constants shared by the decrement-skip execution block
package dec_skip_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int MEM_DEPTH = 160;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DEC_STEP = 8'h01;
    localparam logic [7:0] ZERO_VALUE = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int SKIP_CYCLES = 2;
    localparam int RUN_CYCLES = 1;
endpackage

// file: rtl/data_ram.sv
// small data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module data_ram #(
    parameter int DW = 8,
    parameter int AW = 8,
    parameter int DEPTH = 160
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    // storage array, no reset so it maps to ram
    always_ff @(posedge clk) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read register; out of range reads return zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/dec_skip_exec.sv
// execution of decrement_skip_zero_into_accumulator with its data memory
//
// Overview of operation
// - read addressed data memory operand and compute operand minus one
// - write the decremented result into the accumulator register
// - never write data memory back during this instruction
// - zero result skips the immediately following instruction
// - zero result discards prefetched instruction, adds dummy cycle: two cycles total
// - nonzero result proceeds directly; instruction takes one machine cycle
`timescale 1ns/1ps
`default_nettype none
module dec_skip_exec (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // instruction issue from decode
    input wire logic EXEC_VALID,
    input wire logic [dec_skip_pkg::ADDR_W-1:0] OPERAND_ADDR,
    // memory loading port for other instructions
    input wire logic LOAD_EN,
    input wire logic [dec_skip_pkg::ADDR_W-1:0] LOAD_ADDR,
    input wire logic [dec_skip_pkg::DATA_W-1:0] LOAD_DATA,
    // status flags from the rest of the core
    input wire logic [dec_skip_pkg::DATA_W-1:0] FLAGS_IN,
    // results
    output logic [dec_skip_pkg::DATA_W-1:0] ACCUMULATOR_REGISTER,
    output logic [dec_skip_pkg::DATA_W-1:0] FLAGS_OUT,
    output logic DONE,
    output logic SKIP_DONE,
    output logic FLUSH_PREFETCH,
    output logic BUSY
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DUMMY} state_e;

    state_e state_reg, state_next;
    logic [dec_skip_pkg::DATA_W-1:0] acc_reg, acc_next;
    logic [dec_skip_pkg::DATA_W-1:0] flags_reg;
    logic done_reg, done_next, skip_reg, skip_next, flush_reg, flush_next, busy_reg, busy_next;
    logic [dec_skip_pkg::DATA_W-1:0] operand;
    logic mem_wr_en;

    // memory writes come only from the load port; this op never writes back
    assign mem_wr_en = LOAD_EN && !busy_reg;

    data_ram #(
        .DW(dec_skip_pkg::DATA_W),
        .AW(dec_skip_pkg::ADDR_W),
        .DEPTH(dec_skip_pkg::MEM_DEPTH)
    ) u_ram (
        .clk(CLK),
        .rst_n(RST_N),
        .wr_en(mem_wr_en),
        .wr_addr(LOAD_ADDR),
        .wr_data(LOAD_DATA),
        .rd_addr(OPERAND_ADDR),
        .rd_data(operand)
    );

    // zero test shared by the skip decision and the checks below
    function automatic logic is_zero(input logic [dec_skip_pkg::DATA_W-1:0] value);
        return value == dec_skip_pkg::ZERO_VALUE;
    endfunction

    // decrement and zero test on the registered read data
    // the read register costs a state, but keeps the decrement off the array path
    wire [dec_skip_pkg::DATA_W-1:0] dec_result = operand - dec_skip_pkg::DEC_STEP;
    wire dec_zero = is_zero(dec_result);
    wire in_read = (state_reg == ST_READ);
    wire in_dummy = (state_reg == ST_DUMMY);
    // a start is only taken from idle; a start while busy is dropped
    wire take = (state_reg == ST_IDLE) && EXEC_VALID;

    // next state: the ram read latency is hidden in the read state
    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        done_next = 1'b0;
        skip_next = 1'b0;
        flush_next = 1'b0;
        busy_next = busy_reg;
        case (state_reg)
            ST_IDLE: begin
                // the ram samples the operand address on this same edge
                if (EXEC_VALID) begin
                    state_next = ST_READ;
                    busy_next = 1'b1;
                end
            end
            ST_READ: begin
                acc_next = dec_result;
                // zero result spends the dummy cycle so the refetch can land
                if (dec_zero) begin
                    state_next = ST_DUMMY;
                    flush_next = 1'b1;
                end else begin
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                    busy_next = 1'b0;
                end
            end
            ST_DUMMY: begin
                state_next = ST_IDLE;
                done_next = 1'b1;
                skip_next = 1'b1;
                busy_next = 1'b0;
            end
            default: begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    // state and output registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            acc_reg <= dec_skip_pkg::ACC_RESET;
            done_reg <= 1'b0;
            skip_reg <= 1'b0;
            flush_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            done_reg <= done_next;
            skip_reg <= skip_next;
            flush_reg <= flush_next;
            busy_reg <= busy_next;
        end
    end

    // flags pass through untouched, only retimed
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_reg <= dec_skip_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= FLAGS_IN;
        end
    end

    assign ACCUMULATOR_REGISTER = acc_reg;
    assign FLAGS_OUT = flags_reg;
    assign DONE = done_reg;
    assign SKIP_DONE = skip_reg;
    assign FLUSH_PREFETCH = flush_reg;
    assign BUSY = busy_reg;

    // accumulator takes operand minus one after the read state
    acc_update_a: assert property (@(posedge CLK) disable iff (!RST_N)
        in_read |=> acc_reg == $past(operand) - dec_skip_pkg::DEC_STEP)
        else $error("accumulator not loaded with decremented operand");

    // no ram write while busy
    no_writeback_a: assert property (@(posedge CLK) disable iff (!RST_N)
        busy_reg |-> !mem_wr_en)
        else $error("data memory written during instruction");

    // zero result flushes then finishes with skip one cycle later
    zero_skip_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (in_read && dec_zero) |=> flush_reg ##1 (done_reg && skip_reg))
        else $error("zero result did not flush and skip");

    // nonzero result finishes next cycle without skip
    nonzero_run_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (in_read && !dec_zero) |=> (done_reg && !skip_reg && !flush_reg))
        else $error("nonzero result did not finish in one cycle");

    // skip only follows a zero result
    skip_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
        skip_reg |-> $past(flush_reg) && $past(acc_reg) == dec_skip_pkg::ZERO_VALUE)
        else $error("skip without zero result");

    // flags copied unchanged; the first edge out of reset still shows the reset value
    flags_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(RST_N) |-> FLAGS_OUT == $past(FLAGS_IN))
        else $error("status flags altered");

    // result sits one below the operand, wrapping from zero to all ones
    dec_source_a: assert property (@(posedge CLK) disable iff (!RST_N)
        in_read |-> (dec_result + dec_skip_pkg::DEC_STEP == operand)
            && (dec_zero == (operand == dec_skip_pkg::DEC_STEP)))
        else $error("decrement not taken from operand");

    // a taken start enters the read state with busy raised
    busy_after_take_a: assert property (@(posedge CLK) disable iff (!RST_N)
        take |=> busy_reg && in_read)
        else $error("start not taken from idle");

    // the read state lasts exactly one cycle
    read_once_a: assert property (@(posedge CLK) disable iff (!RST_N)
        in_read |=> !in_read)
        else $error("read state repeated");

    // accumulator only moves when the read state loads it
    acc_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !in_read |=> $stable(acc_reg))
        else $error("accumulator changed outside the read state");

    // dummy cycle keeps the zero result and still counts as busy
    dummy_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        in_dummy |-> busy_reg && is_zero(acc_reg) && !done_reg)
        else $error("dummy cycle lost its zero result");

    // prefetch discard only on a zero result
    flush_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
        flush_reg |-> in_dummy && is_zero(acc_reg))
        else $error("prefetch discarded on nonzero result");

    // skip is only reported together with completion
    skip_with_done_a: assert property (@(posedge CLK) disable iff (!RST_N)
        skip_reg |-> done_reg && !busy_reg)
        else $error("skip reported outside completion");

    // completion is a one cycle pulse that has dropped busy
    done_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
        done_reg |-> !busy_reg ##1 !done_reg)
        else $error("completion held or busy left high");

    // busy mirrors the state, so the issue side never sees a stale busy
    busy_state_a: assert property (@(posedge CLK) disable iff (!RST_N)
        busy_reg == !(state_reg == ST_IDLE))
        else $error("busy does not match the instruction state");
endmodule
`default_nettype wire

// file: bench/dec_skip_exec_tb.sv
// self-checking bench for the decrement-skip execution block
`timescale 1ns/1ps
`default_nettype none
module dec_skip_exec_tb;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic EXEC_VALID = 1'b0;
    logic [7:0] OPERAND_ADDR = 8'h00;
    logic LOAD_EN = 1'b0;
    logic [7:0] LOAD_ADDR = 8'h00;
    logic [7:0] LOAD_DATA = 8'h00;
    logic [7:0] FLAGS_IN = 8'h00;
    logic [7:0] ACCUMULATOR_REGISTER;
    logic [7:0] FLAGS_OUT;
    logic DONE;
    logic SKIP_DONE;
    logic FLUSH_PREFETCH;
    logic BUSY;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    dec_skip_exec i_dut (.CLK(CLK), .RST_N(RST_N), .EXEC_VALID(EXEC_VALID),
        .OPERAND_ADDR(OPERAND_ADDR), .LOAD_EN(LOAD_EN), .LOAD_ADDR(LOAD_ADDR),
        .LOAD_DATA(LOAD_DATA), .FLAGS_IN(FLAGS_IN),
        .ACCUMULATOR_REGISTER(ACCUMULATOR_REGISTER), .FLAGS_OUT(FLAGS_OUT),
        .DONE(DONE), .SKIP_DONE(SKIP_DONE), .FLUSH_PREFETCH(FLUSH_PREFETCH), .BUSY(BUSY));

    // 50 MHz core clock
    always #10 CLK = ~CLK;

    // hang guard: the whole run needs well under a hundred cycles
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // preload one memory byte while the block is idle
    task automatic load(input logic [7:0] a, input logic [7:0] d);
        LOAD_EN = 1'b1;
        LOAD_ADDR = a;
        LOAD_DATA = d;
        @(negedge CLK);
        LOAD_EN = 1'b0;
    endtask

    // issue one instruction; address held through the take edge, where the ram read samples it
    task automatic run_op(input logic [7:0] a, input logic [7:0] exp, input logic zero);
        int k;
        int flush_at;
        k = 0;
        flush_at = 0;
        EXEC_VALID = 1'b1;
        OPERAND_ADDR = a;
        @(negedge CLK);
        EXEC_VALID = 1'b0;
        chk(BUSY === 1'b1, "busy not raised");
        while (DONE !== 1'b1 && k < 8) begin
            @(negedge CLK);
            k++;
            if (FLUSH_PREFETCH === 1'b1) flush_at = k;
        end
        chk(k == (zero ? 2 : 1), "completion cycle count");
        chk(flush_at == (zero ? 1 : 0), "prefetch discard");
        chk(BUSY === 1'b0, "busy left high at completion");
        chk(ACCUMULATOR_REGISTER === exp, "accumulator result");
        chk(SKIP_DONE === zero, "skip indication");
        chk(FLAGS_OUT === FLAGS_IN, "flags disturbed");
    endtask

    task automatic test_nonzero();
        load(8'h10, 8'h05);
        run_op(8'h10, 8'h04, 1'b0);
    endtask

    task automatic test_zero();
        load(8'h11, 8'h01);
        run_op(8'h11, 8'h00, 1'b1);
    endtask

    // back-to-back reuse: a write-back would change the second result
    task automatic test_unchanged();
        run_op(8'h10, 8'h04, 1'b0);
        run_op(8'h11, 8'h00, 1'b1);
        run_op(8'h11, 8'h00, 1'b1);
    endtask

    // zero operand wraps to all ones, which must not skip
    task automatic test_wrap();
        load(8'h9F, 8'h00);
        run_op(8'h9F, 8'hFF, 1'b0);
    endtask

    // a load and a repeated start inside a zero-result op must both be dropped
    task automatic test_refused();
        load(8'h12, 8'h01);
        EXEC_VALID = 1'b1;
        OPERAND_ADDR = 8'h12;
        @(negedge CLK);
        LOAD_EN = 1'b1;
        LOAD_ADDR = 8'h12;
        LOAD_DATA = 8'h05;
        repeat (2) @(negedge CLK);
        chk(DONE === 1'b1 && SKIP_DONE === 1'b1, "zero op upset by refused inputs");
        EXEC_VALID = 1'b0;
        LOAD_EN = 1'b0;
        @(negedge CLK);
        run_op(8'h12, 8'h00, 1'b1);
    endtask

    task automatic test_flags();
        FLAGS_IN = 8'hA5;
        @(negedge CLK);
        run_op(8'h11, 8'h00, 1'b1);
        FLAGS_IN = 8'h5A;
        @(negedge CLK);
        run_op(8'h10, 8'h04, 1'b0);
    endtask

    initial begin
        repeat (4) @(negedge CLK);
        RST_N = 1'b1;
        @(negedge CLK);
        test_nonzero();
        test_zero();
        test_unchanged();
        test_wrap();
        test_refused();
        test_flags();
        stop_test();
    end
endmodule
`default_nettype wire
